/* File: logic/ext_regs_cfg.svh */
`ifndef EXT_REGS_CFG_SVH
`define EXT_REGS_CFG_SVH
// Slot numbers on the extension port
`define SLOT_SYMERR_HIGH 3'h2
`define SLOT_RSVD_LO 3'h3
`define SLOT_RSVD_HI 3'h5
`define SLOT_CONTROL 3'h6
`define SLOT_SWITCH 3'h7
`define SLOT_SYMERR_LOW 3'h6
// Control field positions
`define CTL_FS_IRQ_BIT 10
`define CTL_IRQ0_BIT 9
`define CTL_IRQ2_BIT 8
`define CTL_WAKE_HI 7
`define CTL_WAKE_LO 4
`define CTL_DAC_HI 3
`define CTL_DAC_LO 0
// Switch register fields
`define SW_POL_BIT 15
`define SW_ON_HI 14
`define SW_ON_LO 8
`define SW_OFF_HI 6
`define SW_OFF_LO 0
// Fixed upper bits of the 9-bit times
`define ON_MSB_BASE 2'h0
`define ON_MSB_HANDSET 2'h1
`define OFF_MSB_BASE 2'h1
`define OFF_MSB_HANDSET 2'h2
// Reset values
`define CTL_RESET 11'h000
`define DAC_RESET 4'h0
`define SW_TIME_RESET 7'h00
// Debounce limit; wake needs one low bit-clock sample more than this
`define DEBOUNCE_SAMPLES 3'h3
`endif

/* File: logic/ext_regs_pkg.sv */
package ext_regs_pkg;
  typedef logic [15:0] word_t;
  typedef logic [2:0] slot_t;
  typedef logic [8:0] frame_count_t;
  typedef enum logic {bank_zero, bank_one} bank_t;
endpackage

/* File: logic/wake_filter.sv */
`include "ext_regs_cfg.svh"
module wake_filter
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic bit_tick,
  input wire logic pin_n,
  input wire logic enable,
  output logic wake
);
  logic s1_q;
  logic s2_q;
  logic [2:0] cnt_q;
  logic stable_q;
  logic hold_q;
  // ***************************
  // Two-stage pin synchroniser
  // ***************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
    end
    else
    begin
      s1_q <= pin_n;
      s2_q <= s1_q;
    end
  end
  // ***************************
  // Debounce on bit clock
  // ***************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cnt_q <= 3'h0;
      stable_q <= 1'b0;
    end
    else if (bit_tick)
    begin
      if (!s2_q && enable) // RL6
      begin
        if (cnt_q == `DEBOUNCE_SAMPLES) // RL7
          stable_q <= 1'b1;
        else
          cnt_q <= cnt_q + 3'h1;
      end
      else
      begin
        cnt_q <= 3'h0;
        stable_q <= 1'b0;
      end
    end
  end
  // ***************************
  // Stretch to one bit minimum
  // ***************************
  // Held across the next bit tick so software sees it leaving sleep
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      hold_q <= 1'b0;
    else if (bit_tick)
      hold_q <= stable_q; // RL8
  end
  assign wake = stable_q | hold_q; // RL8
endmodule

/* File: logic/ext_control_regs.sv */
// Contract
// (RL1) Software leaves bank-1 slots three to five alone or writes zero; they read zero.
// (RL2) Control bit a enables the frame-start interrupt, reset zero.
// (RL3) Control bit 9 enables external interrupt zero, reset zero.
// (RL4) Control bit 8 enables external interrupt two, reset zero.
// (RL5) Control bits 7..4 enable wake pins 3..0 when input mode; reset zero.
// (RL6) Enabled wake pin requests sleep exit when low.
// (RL7) Wake inputs are debounced and synchronised to the bit clock.
// (RL8) Detected wake event lasts at least one bit period.
// (RL9) Control bits 3..0 hold the transmit power DAC value.
// (RL10) Bank-0 slot six reads symbol error low byte; upper zero; writes ignored.
// (RL11) Bank-1 slot two reads symbol error bits 23..8.
// (RL12) Switch polarity bit zero: tx switch active low, rx active high; one reverses.
// (RL13) Switch bits e..8 set turn-on time low seven bits, minus one; read zero.
// (RL14) Switch bits 6..0 set turn-off time low seven bits, minus one; read zero.
// (RL15) Switch times count transmit bit periods against the transmit frame counter.
// (RL16) Switch times are nine bits; upper two supplied by device role.
// (RL17) Turn-on upper bits: 00 base, 01 handset.
// (RL18) Turn-off upper bits: 01 base, 10 handset.
// (RL19) Switch field writes act on outputs immediately.
// (RL20) Transmit enable cleared holds the tx switch inactive.
// (RL21) Tx switch on at turn-on count, off at turn-off count; rx is complement.
`include "ext_regs_cfg.svh"
module ext_control_regs
  import ext_regs_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic bit_tick,
  input wire ext_regs_pkg::bank_t bank,
  input wire ext_regs_pkg::slot_t slot,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire ext_regs_pkg::word_t wr_data,
  output ext_regs_pkg::word_t rd_data,
  input wire logic [23:0] symbol_error,
  input wire ext_regs_pkg::frame_count_t tx_frame_count,
  input wire logic tx_enable,
  input wire logic handset_mode,
  input wire logic [3:0] wake_pins_n,
  input wire logic [3:0] wake_pin_is_input,
  input wire logic frame_start_event,
  input wire logic port_pin_irq_zero,
  input wire logic port_pin_irq_two,
  output logic frame_start_irq,
  output logic ext_irq_zero,
  output logic ext_irq_two,
  output logic [3:0] wake_request,
  output logic [3:0] tx_power_dac_value,
  output logic tx_switch_out,
  output logic rx_switch_out
);
  import ext_regs_pkg::*;
  logic r1_q;
  logic rst_n;
  logic frame_start_irq_en_q;
  logic irq0_en_q;
  logic irq2_en_q;
  logic [3:0] wake_pin_enables_q;
  logic [3:0] dac_q;
  logic rf_switch_polarity_q;
  logic [6:0] on_low_q;
  logic [6:0] off_low_q;
  logic tx_active_q;
  logic irq0_s1_q;
  logic irq0_s2_q;
  logic irq2_s1_q;
  logic irq2_s2_q;
  logic wr_ctl;
  logic wr_sw;
  frame_count_t on_time;
  frame_count_t off_time;
  logic [1:0] on_role;
  logic [1:0] off_role;
  logic on_hit;
  logic off_hit;
  word_t rd_next;
  // ***************************
  // Reset release
  // ***************************
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      r1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      r1_q <= 1'b1;
      rst_n <= r1_q;
    end
  end
  // ***************************
  // Write decode
  // ***************************
  // Bank-1 slots 3..5 and 7 and bank-0 slots 0..5 decode to nothing
  always_comb
  begin
    wr_ctl = 1'b0;
    wr_sw = 1'b0;
    if (wr_en && bank == bank_one && slot == `SLOT_CONTROL)
      wr_ctl = 1'b1; // RL1
    if (wr_en && bank == bank_zero && slot == `SLOT_SWITCH)
      wr_sw = 1'b1;
  end
  // ***************************
  // Control register
  // ***************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      frame_start_irq_en_q <= 1'b0; // RL2
    else if (wr_ctl)
      frame_start_irq_en_q <= wr_data[`CTL_FS_IRQ_BIT]; // RL2
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq0_en_q <= 1'b0; // RL3
    else if (wr_ctl)
      irq0_en_q <= wr_data[`CTL_IRQ0_BIT]; // RL3
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      irq2_en_q <= 1'b0; // RL4
    else if (wr_ctl)
      irq2_en_q <= wr_data[`CTL_IRQ2_BIT]; // RL4
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      wake_pin_enables_q <= 4'h0; // RL5
    else if (wr_ctl)
      wake_pin_enables_q <= wr_data[`CTL_WAKE_HI:`CTL_WAKE_LO]; // RL5
  end
  // Undefined at reset in the device; zero here for determinism
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      dac_q <= `DAC_RESET;
    else if (wr_ctl)
      dac_q <= wr_data[`CTL_DAC_HI:`CTL_DAC_LO]; // RL9
  end
  assign tx_power_dac_value = dac_q; // RL9
  // ***************************
  // Switch timing register
  // ***************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rf_switch_polarity_q <= 1'b0;
    else if (wr_sw)
      rf_switch_polarity_q <= wr_data[`SW_POL_BIT]; // RL12
  end
  // Written zero wraps to 127, as the modulo rule wants
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      on_low_q <= `SW_TIME_RESET;
    else if (wr_sw)
      on_low_q <= wr_data[`SW_ON_HI:`SW_ON_LO] - 7'h01; // RL13
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      off_low_q <= `SW_TIME_RESET;
    else if (wr_sw)
      off_low_q <= wr_data[`SW_OFF_HI:`SW_OFF_LO] - 7'h01; // RL14
  end
  // Role bits follow handset_mode live; nothing latched at write time
  assign on_role = handset_mode ? `ON_MSB_HANDSET : `ON_MSB_BASE; // RL17
  assign off_role = handset_mode ? `OFF_MSB_HANDSET : `OFF_MSB_BASE; // RL18
  assign on_time = {on_role, on_low_q}; // RL16
  assign off_time = {off_role, off_low_q}; // RL16
  // ***************************
  // Switch sequencing
  // ***************************
  // Compared with the transmit frame counter every clock, so new times act at once
  assign on_hit = tx_frame_count == on_time; // RL15
  assign off_hit = tx_frame_count == off_time; // RL15
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_active_q <= 1'b0;
    else if (!tx_enable)
      tx_active_q <= 1'b0; // RL20
    else if (off_hit) // RL21
      tx_active_q <= 1'b0;
    else if (on_hit) // RL21
      tx_active_q <= 1'b1;
  end
  // Off wins on equal times, so an empty window never keys the switch
  // ***************************
  // Switch outputs
  // ***************************
  // Gate on tx_enable directly; polarity applied combinationally
  assign tx_switch_out = (tx_active_q & tx_enable) ^ ~rf_switch_polarity_q; // RL12 RL19 RL20
  assign rx_switch_out = ~tx_switch_out; // RL12 RL21
  // ***************************
  // Interrupt pins
  // ***************************
  // Both pins are asynchronous to clk
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq0_s1_q <= 1'b0;
      irq0_s2_q <= 1'b0;
    end
    else
    begin
      irq0_s1_q <= port_pin_irq_zero;
      irq0_s2_q <= irq0_s1_q;
    end
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq2_s1_q <= 1'b0;
      irq2_s2_q <= 1'b0;
    end
    else
    begin
      irq2_s1_q <= port_pin_irq_two;
      irq2_s2_q <= irq2_s1_q;
    end
  end
  assign ext_irq_zero = irq0_s2_q & irq0_en_q; // RL3
  assign ext_irq_two = irq2_s2_q & irq2_en_q; // RL4
  // ***************************
  // Frame-start interrupt
  // ***************************
  // Event already on clk, so no synchroniser
  assign frame_start_irq = frame_start_event & frame_start_irq_en_q; // RL2
  // ***************************
  // Wake-up pins
  // ***************************
  // Output-mode pins never wake the device
  wake_filter wake_filter_0
  (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .pin_n(wake_pins_n[0]),
    .enable(wake_pin_enables_q[0] & wake_pin_is_input[0]), // RL5
    .wake(wake_request[0])
  );
  wake_filter wake_filter_1
  (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .pin_n(wake_pins_n[1]),
    .enable(wake_pin_enables_q[1] & wake_pin_is_input[1]), // RL5
    .wake(wake_request[1])
  );
  wake_filter wake_filter_2
  (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .pin_n(wake_pins_n[2]),
    .enable(wake_pin_enables_q[2] & wake_pin_is_input[2]), // RL5
    .wake(wake_request[2])
  );
  wake_filter wake_filter_3
  (
    .clk(clk),
    .rst_n(rst_n),
    .bit_tick(bit_tick),
    .pin_n(wake_pins_n[3]),
    .enable(wake_pin_enables_q[3] & wake_pin_is_input[3]), // RL5
    .wake(wake_request[3])
  );
  // ***************************
  // Read mux
  // ***************************
  // No read side effects, so back-to-back reads are safe
  always_comb
  begin
    rd_next = 16'h0000; // RL1
    case ({bank, slot})
      {bank_one, `SLOT_CONTROL}:
        rd_next = {5'h00, frame_start_irq_en_q, irq0_en_q, irq2_en_q,
                   wake_pin_enables_q, dac_q};
      {bank_one, `SLOT_SYMERR_HIGH}:
        rd_next = symbol_error[23:8]; // RL11
      {bank_zero, `SLOT_SYMERR_LOW}:
        rd_next = {8'h00, symbol_error[7:0]}; // RL10
      default:
        rd_next = 16'h0000; // RL1 RL13
    endcase
  end
  // ***************************
  // Read register
  // ***************************
  // Registered so data comes from flip-flops; one cycle after rd_en
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      rd_data <= 16'h0000;
    else if (rd_en)
      rd_data <= rd_next;
  end
endmodule

/* File: verif/ext_control_regs_checker.sv */
module ext_control_regs_checker
(
  input wire logic clk,
  input wire logic reset_n,
  input wire ext_regs_pkg::bank_t bank,
  input wire ext_regs_pkg::slot_t slot,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire ext_regs_pkg::word_t wr_data,
  input wire ext_regs_pkg::word_t rd_data,
  input wire logic [23:0] symbol_error,
  input wire logic tx_enable,
  input wire logic frame_start_event,
  input wire logic frame_start_irq,
  input wire logic [3:0] tx_power_dac_value,
  input wire logic tx_switch_out,
  input wire logic rx_switch_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ext_regs_pkg::*;
  default clocking @(posedge clk);
  endclocking
  default disable iff (!reset_n);
  AST_FS_IRQ: assert property (frame_start_irq |-> frame_start_event)
    else $error("frame irq without event");
  AST_FS_IRQ_EN: assert property (wr_en && bank == bank_one && slot == 3'h6 ##1 frame_start_event
    |-> frame_start_irq == $past(wr_data[10]))
    else $error("frame irq enable not as written");
  AST_RX_COMP: assert property (rx_switch_out == !tx_switch_out)
    else $error("rx switch not complement");
  // Write excluded: a polarity change may legally move the pin
  AST_TX_HELD: assert property (!tx_enable && !wr_en ##1 !tx_enable |-> $stable(tx_switch_out))
    else $error("tx switch moved while disabled");
  AST_SYM_LO: assert property (rd_en && bank == bank_zero && slot == 3'h6
    |=> rd_data == {8'h00, $past(symbol_error[7:0])})
    else $error("symbol error low read wrong");
  AST_SYM_HI: assert property (rd_en && bank == bank_one && slot == 3'h2
    |=> rd_data == $past(symbol_error[23:8]))
    else $error("symbol error high read wrong");
  AST_RSVD: assert property (rd_en && bank == bank_one && slot inside {[3'h3:3'h5]}
    |=> rd_data == 16'h0000)
    else $error("reserved slot read not zero");
  AST_SW_RD: assert property (rd_en && bank == bank_zero && slot == 3'h7
    |=> rd_data == 16'h0000)
    else $error("switch register read not zero");
  AST_DAC: assert property (wr_en && bank == bank_one && slot == 3'h6
    |=> tx_power_dac_value == $past(wr_data[3:0]))
    else $error("dac value not written");
endmodule

/* File: verif/frame_source.sv */
module frame_source
(
  input wire logic clk,
  input wire logic reset_n,
  output logic bit_tick,
  output ext_regs_pkg::frame_count_t tx_frame_count
);
  timeunit 1ns;
  timeprecision 1ns;
  import ext_regs_pkg::*;
  logic [1:0] div_q;
  // Four clocks a bit keeps a frame short
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      div_q <= 2'h0;
    else
      div_q <= div_q + 2'h1;
  end
  assign bit_tick = div_q == 2'h3;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      tx_frame_count <= 9'h000;
    else if (bit_tick)
      tx_frame_count <= tx_frame_count + 9'h001;
  end
endmodule

/* File: verif/ext_control_regs_tb.sv */
module ext_control_regs_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import ext_regs_pkg::*;
  logic clk, reset_n, rd_en, wr_en, tx_en, hs, fs_ev, pin0, pin2, fs_irq, irq0, irq2, tx, rx, tick;
  bank_t bank;
  slot_t slot;
  word_t wr_data, rd_data;
  frame_count_t count;
  logic [3:0] pins_n, is_in, wake, dac;
  int failures, checks_done, i, on, off;
  ext_control_regs ext_control_regs_i (.clk(clk), .reset_n(reset_n), .bit_tick(tick),
    .bank(bank), .slot(slot), .rd_en(rd_en), .wr_en(wr_en), .wr_data(wr_data),
    .rd_data(rd_data), .symbol_error(24'ha5c3e1), .tx_frame_count(count), .tx_enable(tx_en),
    .handset_mode(hs), .wake_pins_n(pins_n), .wake_pin_is_input(is_in),
    .frame_start_event(fs_ev), .port_pin_irq_zero(pin0), .port_pin_irq_two(pin2),
    .frame_start_irq(fs_irq), .ext_irq_zero(irq0), .ext_irq_two(irq2), .wake_request(wake),
    .tx_power_dac_value(dac), .tx_switch_out(tx), .rx_switch_out(rx));
  frame_source frame_source_i (.clk(clk), .reset_n(reset_n), .bit_tick(tick),
    .tx_frame_count(count));
  task automatic cmp(string what, word_t exp, word_t got);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic close_out;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic access(bank_t b, slot_t s, logic w, word_t d);
    @(posedge clk);
    #2;
    bank = b;
    slot = s;
    wr_en = w;
    rd_en = !w;
    wr_data = d;
    @(posedge clk);
    #2;
    wr_en = 0;
    rd_en = 0;
  endtask
  task automatic rd(bank_t b, slot_t s, word_t exp, string what);
    access(b, s, 1'b0, 16'h0000);
    cmp(what, exp, rd_data);
  endtask
  // Bounded: a stuck counter ends the run
  task automatic wait_count(int n);
    for (i = 0; i < 3000 && count !== n[8:0]; i++) #50;
    cmp("count", n[15:0], {7'h00, count});
    if (i == 3000)
      close_out();
  endtask
  initial
  begin
    clk = 0;
    forever #25 clk = ~clk;
  end
  initial
  begin
    {reset_n, rd_en, wr_en, hs, fs_ev, pin0, pin2, slot, wr_data} = '0;
    bank = bank_zero;
    tx_en = 1'b1;
    pins_n = 4'hf;
    is_in = 4'h1;
    repeat (4) @(posedge clk);
    #2 reset_n = 1;
    repeat (3) @(posedge clk);
    rd(bank_one, 3'h6, 16'h0000, "ctl reset");
    access(bank_one, 3'h6, 1'b1, 16'hffff);
    rd(bank_one, 3'h6, 16'h07ff, "ctl");
    cmp("dac", 16'h000f, {12'h000, dac});
    {fs_ev, pin0, pin2} = 3'h7;
    repeat (3) @(posedge clk);
    #2 cmp("irq", 16'h0007, {13'h0000, fs_irq, irq0, irq2});
    access(bank_one, 3'h6, 1'b1, 16'h0000);
    cmp("irq off", 16'h0000, {13'h0000, fs_irq, irq0, irq2});
    access(bank_zero, 3'h6, 1'b1, 16'hffff);
    rd(bank_zero, 3'h6, 16'h00e1, "sym lo");
    rd(bank_one, 3'h2, 16'ha5c3, "sym hi");
    for (slot_t s = 3'h3; s <= 3'h5; s++)
    begin
      access(bank_one, s, 1'b1, 16'h0000);
      rd(bank_one, s, 16'h0000, "rsvd");
    end
    for (int h = 0; h < 2; h++)
    begin
      hs = h[0];
      on = h ? 144 : 16;
      off = h ? 288 : 160;
      access(bank_zero, 3'h7, 1'b1, 16'h1121);
      wait_count(on + 1);
      cmp("tx on", 16'h0000, {15'h0000, tx});
      wait_count(off + 1);
      cmp("tx off", 16'h0001, {15'h0000, tx});
    end
    access(bank_zero, 3'h7, 1'b1, 16'h9121);
    cmp("polarity", 16'h0000, {15'h0000, tx});
    rd(bank_zero, 3'h7, 16'h0000, "sw read");
    tx_en = 0;
    wait_count(on + 1);
    cmp("tx held", 16'h0000, {15'h0000, tx});
    tx_en = 1;
    access(bank_one, 3'h6, 1'b1, 16'h0030);
    pins_n = 4'hc;
    for (i = 0; i < 200 && wake[0] !== 1'b1; i++) #50;
    cmp("debounce", 16'h0001, {15'h0000, i > 10});
    cmp("wake", 16'h0001, {12'h000, wake});
    if (i == 200)
      close_out();
    pins_n = 4'hf;
    #250 cmp("stretch", 16'h0001, {15'h0000, wake[0]});
    for (i = 0; i < 40 && wake[0] !== 1'b0; i++) #50;
    cmp("wake release", 16'h0000, {12'h000, wake});
    close_out();
  end
endmodule
bind ext_control_regs ext_control_regs_checker ext_control_regs_checker_i (.clk(clk),
  .reset_n(reset_n), .bank(bank), .slot(slot), .rd_en(rd_en), .wr_en(wr_en),
  .wr_data(wr_data), .rd_data(rd_data), .symbol_error(symbol_error), .tx_enable(tx_enable),
  .frame_start_event(frame_start_event), .frame_start_irq(frame_start_irq),
  .tx_power_dac_value(tx_power_dac_value), .tx_switch_out(tx_switch_out),
  .rx_switch_out(rx_switch_out));
